// ### rtl/asl_flash.sv
`timescale 1ns/1ps
module asl_flash (
   input wire logic clk,
   input wire logic rst_n,
   asl_led_if.pat led
);
   typedef struct packed {
      logic red;
      logic green;
   } asl_flash_st_t;

   asl_flash_st_t cur_ff;
   asl_flash_st_t nxt_ff;

   // colour pattern per indication and step, {red, green}
   function automatic logic [1:0] asl_pattern(input asl_pkg::asl_ind_t ind,
                                              input logic [3:0] s,
                                              input logic rev_phase,
                                              input logic [2:0] btype,
                                              input logic [2:0] brev);
      logic [1:0] c;
      c = 2'h0;
      case (ind)
         asl_pkg::IND_NODATA: c = 2'h0;
         asl_pkg::IND_NOLOCK: c = 2'h2;
         asl_pkg::IND_CODEV: c = {s[1], 1'b0};
         asl_pkg::IND_OVF: c = {~s[3], 1'b0};
         asl_pkg::IND_VUNK: c = {1'b0, s[2]};
         asl_pkg::IND_V188: c = 2'h1;
         asl_pkg::IND_V188I: c = {1'b0, s != 4'h0};
         asl_pkg::IND_V204: c = {1'b0, s[3:1] != 3'h7};
         asl_pkg::IND_V204I: c = {1'b0, (s[3:1] != 3'h7) && (s != 4'h0)};
         asl_pkg::IND_CHRST: c = 2'h3;
         asl_pkg::IND_PWR:
         begin
            // red flash count gives board type, then green count gives revision
            if (rev_phase)
            begin
               c = {1'b0, s[0] && (s[3:1] < brev)};
            end
            else
            begin
               c = {s[0] && (s[3:1] < btype), 1'b0};
            end
         end
         default: c = 2'h0;
      endcase
      return c;
   endfunction : asl_pattern

   // override replaces the automatic pattern
   always_comb
   begin
      nxt_ff = cur_ff;
      if (led.ovr_en)
      begin
         {nxt_ff.red, nxt_ff.green} = {led.ovr_red, led.ovr_green};
      end
      else
      begin
         {nxt_ff.red, nxt_ff.green} = asl_pattern(led.ind, led.step, led.pwr_rev_phase,
                                                  led.pwr_type, led.pwr_rev);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   assign led.red = cur_ff.red;
   assign led.green = cur_ff.green;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_CHRST_AMBER: assert property (led.ind == asl_pkg::IND_CHRST && !led.ovr_en
      |=> led.red && led.green)
      else $error("channel reset not shown in both colours");
   AST_INV_GAP: assert property (led.ind == asl_pkg::IND_V188I && !led.ovr_en
      && led.step == 4'h0 ##1 led.step == 4'h0 |-> !led.green)
      else $error("inverted input gap missing");
endmodule : asl_flash

// ### rtl/asl_led_if.sv
`timescale 1ns/1ps
interface asl_led_if;
   asl_pkg::asl_ind_t ind;
   logic [3:0] step;
   logic pwr_rev_phase;
   logic [2:0] pwr_type;
   logic [2:0] pwr_rev;
   logic ovr_en;
   logic ovr_red;
   logic ovr_green;
   logic red;
   logic green;

   modport drv (output ind, step, pwr_rev_phase, pwr_type, pwr_rev, ovr_en, ovr_red, ovr_green,
                input red, green);
   modport pat (input ind, step, pwr_rev_phase, pwr_type, pwr_rev, ovr_en, ovr_red, ovr_green,
                output red, green);
endinterface : asl_led_if

// ### rtl/asl_pkg.sv
package asl_pkg;
   // clock and flash timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MS = 50;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int PRESC_W = 21;
   localparam logic [3:0] STEP_LAST = 4'hF;
   localparam logic [3:0] ERR_HOLD = 4'h2;
   // receive buffer sizing
   localparam int FIFO_BYTES = 8 * 1024 * 1024;
   localparam int RATE_MBPS = 214;
   localparam int LAT_MS = 314;
   // register map, byte addresses
   localparam int AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_CV_CNT = 8'h10;
   localparam logic [7:0] REG_OVF_CNT = 8'h14;
   localparam logic [7:0] REG_FIFO_DATA = 8'h18;
   localparam logic [7:0] REG_ID = 8'h1C;
   // control fields
   localparam int CTL_OVR_EN = 0;
   localparam int CTL_OVR_RED = 1;
   localparam int CTL_OVR_GRN = 2;
   localparam int CTL_CH_RST = 3;
   localparam int CTL_DMA_EN = 4;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'h0;
   // interrupt bits
   localparam int IRQ_LOCK_LOST = 0;
   localparam int IRQ_CODE_VIOL = 1;
   localparam int IRQ_OVERFLOW = 2;
   localparam int IRQ_SIZE_CHG = 3;
   // packet size codes and bus response codes
   localparam logic [1:0] SIZE_UNK = 2'h0;
   localparam logic [1:0] SIZE_188 = 2'h1;
   localparam logic [1:0] SIZE_204 = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [10:0] {
      IND_NODATA = 11'h001,
      IND_NOLOCK = 11'h002,
      IND_CODEV = 11'h004,
      IND_OVF = 11'h008,
      IND_VUNK = 11'h010,
      IND_V188 = 11'h020,
      IND_V188I = 11'h040,
      IND_V204 = 11'h080,
      IND_V204I = 11'h100,
      IND_CHRST = 11'h200,
      IND_PWR = 11'h400
   } asl_ind_t;

   typedef enum logic [2:0] {
      ST_PWR_TYPE = 3'h1,
      ST_PWR_REV = 3'h2,
      ST_RUN = 3'h4
   } asl_state_t;
endpackage : asl_pkg

// ### rtl/asl_top.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - bi-colour lamp shows colour plus flash pattern
// - separate indication for every receiver condition except inversion with unknown packet size
// - loss of lock lights red
// - inverted input adds one brief dark step for 188- and 204-byte packets
// - software override drives the lamp directly
// - power-up flashes board type and revision
// - buffer overflow shown as error
// - host reads buffer directly or via DMA
// - buffer of 8 MB absorbs 314 ms
// - status and counters readable, summary on lamp
module asl_top #(
   parameter int TICK_CYC = asl_pkg::TICK_CYC,
   parameter int FIFO_BYTES = asl_pkg::FIFO_BYTES,
   parameter logic [2:0] BOARD_TYPE = 3'h2, // arbitrary value
   parameter logic [2:0] FW_REV = 3'h1 // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rx_carrier,
   input wire logic rx_lock,
   input wire logic rx_code_viol,
   input wire logic rx_inverted,
   input wire logic [1:0] rx_pkt_size,
   input wire logic fifo_overflow,
   input wire logic fifo_empty,
   input wire logic [31:0] fifo_data,
   output logic fifo_pop,
   output logic dma_en,
   output logic chan_rst,
   output logic led_red,
   output logic led_green,
   output logic irq
);
   localparam int PW = asl_pkg::PRESC_W;

   // refuse settings the logic cannot serve
   if (TICK_CYC < 2 || TICK_CYC >= (1 << PW))
   begin : g_chk_tick
      $error("TICK_CYC out of range");
   end
   if (FIFO_BYTES < 1024 || (FIFO_BYTES & (FIFO_BYTES - 1)) != 0)
   begin : g_chk_fifo
      $error("FIFO_BYTES must be a power of two");
   end

   typedef struct packed {
      asl_pkg::asl_state_t st;
      logic [PW-1:0] presc;
      logic tick;
      logic [3:0] step;
      logic [3:0] cv_hold;
      logic [3:0] ovf_hold;
      logic lock_d;
      logic [1:0] size_d;
      logic [7:0] ctrl;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [15:0] cv_cnt;
      logic [15:0] ovf_cnt;
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic pop;
   } asl_top_st_t;

   asl_top_st_t cur_ff;
   asl_top_st_t nxt_ff;
   logic rst_meta_ff;
   logic rst_sync_n_ff;
   asl_pkg::asl_ind_t ind;
   asl_led_if led_bus ();

   // byte-lane merge for writable registers
   function automatic logic [31:0] asl_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : asl_merge

   // reset release through two flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_n_ff <= rst_meta_ff;
      end
   end

   // indication select by priority
   always_comb
   begin
      if (cur_ff.st != asl_pkg::ST_RUN)
      begin
         ind = asl_pkg::IND_PWR;
      end
      else if (cur_ff.ctrl[asl_pkg::CTL_CH_RST])
      begin
         ind = asl_pkg::IND_CHRST;
      end
      else if (rx_carrier && !rx_lock)
      begin
         ind = asl_pkg::IND_NOLOCK;
      end
      else if (cur_ff.cv_hold != 4'h0)
      begin
         ind = asl_pkg::IND_CODEV;
      end
      else if (cur_ff.ovf_hold != 4'h0)
      begin
         ind = asl_pkg::IND_OVF;
      end
      else if (rx_carrier && rx_pkt_size == asl_pkg::SIZE_188)
      begin
         ind = rx_inverted ? asl_pkg::IND_V188I : asl_pkg::IND_V188;
      end
      else if (rx_carrier && rx_pkt_size == asl_pkg::SIZE_204)
      begin
         ind = rx_inverted ? asl_pkg::IND_V204I : asl_pkg::IND_V204;
      end
      else if (rx_carrier)
      begin
         ind = asl_pkg::IND_VUNK;
      end
      else
      begin
         ind = asl_pkg::IND_NODATA;
      end
   end

   // next state of the whole block
   always_comb
   begin
      logic frame_end;
      logic [3:0] ev;
      logic [3:0] clr;
      logic wr_go;
      logic [7:0] wa;
      logic [7:0] ra;
      nxt_ff = cur_ff;
      frame_end = cur_ff.tick && (cur_ff.step == asl_pkg::STEP_LAST);
      ev = '0;
      clr = '0;
      wr_go = cur_ff.aw_full && cur_ff.w_full && !cur_ff.bvalid;
      wa = {cur_ff.awaddr[7:2], 2'h0};
      ra = {s_axi_araddr[7:2], 2'h0};
      nxt_ff.pop = 1'b0;
      // prescaler and step counter
      nxt_ff.tick = 1'b0;
      if (cur_ff.presc == PW'(TICK_CYC - 1))
      begin
         nxt_ff.presc = '0;
         nxt_ff.tick = 1'b1;
      end
      else
      begin
         nxt_ff.presc = cur_ff.presc + 1'b1;
      end
      if (cur_ff.tick)
      begin
         nxt_ff.step = cur_ff.step + 4'h1;
      end
      // power-up sequence, one frame for each field
      case (cur_ff.st)
         asl_pkg::ST_PWR_TYPE: if (frame_end) nxt_ff.st = asl_pkg::ST_PWR_REV;
         asl_pkg::ST_PWR_REV: if (frame_end) nxt_ff.st = asl_pkg::ST_RUN;
         asl_pkg::ST_RUN: nxt_ff.st = asl_pkg::ST_RUN;
         default: nxt_ff.st = asl_pkg::ST_PWR_TYPE;
      endcase
      // error stretch so short events stay visible
      if (rx_code_viol)
      begin
         nxt_ff.cv_hold = asl_pkg::ERR_HOLD;
      end
      else if (frame_end && cur_ff.cv_hold != 4'h0)
      begin
         nxt_ff.cv_hold = cur_ff.cv_hold - 4'h1;
      end
      if (fifo_overflow)
      begin
         nxt_ff.ovf_hold = asl_pkg::ERR_HOLD;
      end
      else if (frame_end && cur_ff.ovf_hold != 4'h0)
      begin
         nxt_ff.ovf_hold = cur_ff.ovf_hold - 4'h1;
      end
      // events
      nxt_ff.lock_d = rx_lock;
      nxt_ff.size_d = rx_pkt_size;
      ev[asl_pkg::IRQ_LOCK_LOST] = cur_ff.lock_d && !rx_lock;
      ev[asl_pkg::IRQ_CODE_VIOL] = rx_code_viol;
      ev[asl_pkg::IRQ_OVERFLOW] = fifo_overflow;
      ev[asl_pkg::IRQ_SIZE_CHG] = rx_lock && (cur_ff.size_d != rx_pkt_size);
      if (rx_code_viol && cur_ff.cv_cnt != 16'hFFFF)
      begin
         nxt_ff.cv_cnt = cur_ff.cv_cnt + 16'h0001;
      end
      if (fifo_overflow && cur_ff.ovf_cnt != 16'hFFFF)
      begin
         nxt_ff.ovf_cnt = cur_ff.ovf_cnt + 16'h0001;
      end
      // write address and data, taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_ff.aw_full = 1'b1;
         nxt_ff.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_ff.w_full = 1'b1;
         nxt_ff.wdata = s_axi_wdata;
         nxt_ff.wstrb = s_axi_wstrb;
      end
      if (wr_go)
      begin
         nxt_ff.aw_full = 1'b0;
         nxt_ff.w_full = 1'b0;
         nxt_ff.bvalid = 1'b1;
         nxt_ff.bresp = asl_pkg::RESP_OKAY;
         case (wa)
            asl_pkg::REG_CTRL:
               nxt_ff.ctrl = 8'(asl_merge({24'h0, cur_ff.ctrl}, cur_ff.wdata, cur_ff.wstrb));
            asl_pkg::REG_IRQ_STAT:
               clr = cur_ff.wstrb[0] ? cur_ff.wdata[3:0] : 4'h0;
            asl_pkg::REG_IRQ_MASK:
               nxt_ff.irq_mask =
                  4'(asl_merge({28'h0, cur_ff.irq_mask}, cur_ff.wdata, cur_ff.wstrb));
            asl_pkg::REG_CV_CNT: nxt_ff.cv_cnt = '0;
            asl_pkg::REG_OVF_CNT: nxt_ff.ovf_cnt = '0;
            asl_pkg::REG_STATUS, asl_pkg::REG_FIFO_DATA, asl_pkg::REG_ID: ;
            default: nxt_ff.bresp = asl_pkg::RESP_DECERR;
         endcase
      end
      else if (cur_ff.bvalid && s_axi_bready)
      begin
         nxt_ff.bvalid = 1'b0;
      end
      // sticky status, a new event wins over a clear
      nxt_ff.irq_stat = (cur_ff.irq_stat & ~clr) | ev;
      // read channel
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_ff.rvalid = 1'b1;
         nxt_ff.rresp = asl_pkg::RESP_OKAY;
         case (ra)
            asl_pkg::REG_CTRL: nxt_ff.rdata = {24'h0, cur_ff.ctrl};
            asl_pkg::REG_STATUS:
               nxt_ff.rdata = {13'h0, ind, cur_ff.st == asl_pkg::ST_RUN,
                               cur_ff.ovf_hold != 4'h0, cur_ff.cv_hold != 4'h0,
                               rx_pkt_size, rx_inverted, rx_lock, rx_carrier};
            asl_pkg::REG_IRQ_STAT: nxt_ff.rdata = {28'h0, cur_ff.irq_stat};
            asl_pkg::REG_IRQ_MASK: nxt_ff.rdata = {28'h0, cur_ff.irq_mask};
            asl_pkg::REG_CV_CNT: nxt_ff.rdata = {16'h0, cur_ff.cv_cnt};
            asl_pkg::REG_OVF_CNT: nxt_ff.rdata = {16'h0, cur_ff.ovf_cnt};
            asl_pkg::REG_FIFO_DATA:
            begin
               // direct read takes the word on offer, zero when empty
               nxt_ff.rdata = fifo_empty ? 32'h0 : fifo_data;
               nxt_ff.pop = !fifo_empty;
            end
            asl_pkg::REG_ID: nxt_ff.rdata = {24'h0, 1'b0, BOARD_TYPE, 1'b0, FW_REV};
            default:
            begin
               nxt_ff.rdata = 32'h0;
               nxt_ff.rresp = asl_pkg::RESP_DECERR;
            end
         endcase
      end
      else if (cur_ff.rvalid && s_axi_rready)
      begin
         nxt_ff.rvalid = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n_ff)
   begin
      if (!rst_sync_n_ff)
      begin
         cur_ff <= '0;
         cur_ff.st <= asl_pkg::ST_PWR_TYPE;
         cur_ff.ctrl <= asl_pkg::CTRL_RST;
         cur_ff.irq_mask <= asl_pkg::MASK_RST;
      end
      else
      begin
         cur_ff <= nxt_ff;
      end
   end

   // bus handshakes and register-driven outputs
   assign s_axi_awready = !cur_ff.aw_full && !cur_ff.bvalid;
   assign s_axi_wready = !cur_ff.w_full && !cur_ff.bvalid;
   assign s_axi_bvalid = cur_ff.bvalid;
   assign s_axi_bresp = cur_ff.bresp;
   assign s_axi_arready = !cur_ff.rvalid;
   assign s_axi_rvalid = cur_ff.rvalid;
   assign s_axi_rdata = cur_ff.rdata;
   assign s_axi_rresp = cur_ff.rresp;
   assign fifo_pop = cur_ff.pop;
   assign dma_en = cur_ff.ctrl[asl_pkg::CTL_DMA_EN];
   assign chan_rst = cur_ff.ctrl[asl_pkg::CTL_CH_RST];
   assign irq = |(cur_ff.irq_stat & cur_ff.irq_mask);

   // lamp pattern generator
   assign led_bus.ind = ind;
   assign led_bus.step = cur_ff.step;
   assign led_bus.pwr_rev_phase = cur_ff.st == asl_pkg::ST_PWR_REV;
   assign led_bus.pwr_type = BOARD_TYPE;
   assign led_bus.pwr_rev = FW_REV;
   assign led_bus.ovr_en = cur_ff.ctrl[asl_pkg::CTL_OVR_EN];
   assign led_bus.ovr_red = cur_ff.ctrl[asl_pkg::CTL_OVR_RED];
   assign led_bus.ovr_green = cur_ff.ctrl[asl_pkg::CTL_OVR_GRN];
   assign led_red = led_bus.red;
   assign led_green = led_bus.green;

   asl_flash u_flash (
      .clk(mclk),
      .rst_n(rst_sync_n_ff),
      .led(led_bus.pat)
   );

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_sync_n_ff);

   AST_NOLOCK_RED: assert property (ind == asl_pkg::IND_NOLOCK
      && !cur_ff.ctrl[asl_pkg::CTL_OVR_EN] |=> led_red && !led_green)
      else $error("no lock not shown red");
   AST_OVR_FOLLOW: assert property (cur_ff.ctrl[asl_pkg::CTL_OVR_EN]
      |=> led_red == $past(cur_ff.ctrl[asl_pkg::CTL_OVR_RED])
          && led_green == $past(cur_ff.ctrl[asl_pkg::CTL_OVR_GRN]))
      else $error("lamp ignores override");
   AST_PWR_SEQ: assert property (cur_ff.st == asl_pkg::ST_PWR_TYPE && cur_ff.tick
      && cur_ff.step == asl_pkg::STEP_LAST |=> cur_ff.st == asl_pkg::ST_PWR_REV
      && ind == asl_pkg::IND_PWR)
      else $error("power-up sequence broken");
   AST_OVF_ERR: assert property (fifo_overflow && cur_ff.st == asl_pkg::ST_RUN
      && !cur_ff.ctrl[asl_pkg::CTL_CH_RST]
      |=> ind inside {asl_pkg::IND_NOLOCK, asl_pkg::IND_CODEV, asl_pkg::IND_OVF})
      else $error("overflow not flagged");
   AST_CHRST_PRIO: assert property (cur_ff.st == asl_pkg::ST_RUN
      && cur_ff.ctrl[asl_pkg::CTL_CH_RST] |-> ind == asl_pkg::IND_CHRST)
      else $error("channel reset lost priority");
   AST_TICK_PULSE: assert property (cur_ff.tick |-> cur_ff.presc == '0 ##1 !cur_ff.tick)
      else $error("prescaler tick malformed");
   AST_NODATA: assert property (cur_ff.st == asl_pkg::ST_RUN && !rx_carrier
      && !cur_ff.ctrl[asl_pkg::CTL_CH_RST] && cur_ff.cv_hold == 4'h0
      && cur_ff.ovf_hold == 4'h0 |-> ind == asl_pkg::IND_NODATA)
      else $error("no data indication wrong");
   AST_IRQ_SET: assert property (fifo_overflow && cur_ff.irq_mask[asl_pkg::IRQ_OVERFLOW]
      |=> irq && cur_ff.irq_stat[asl_pkg::IRQ_OVERFLOW])
      else $error("overflow interrupt missing");
   AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   COV_PWR_DONE: cover property (led_bus.pwr_rev_phase ##1 cur_ff.st == asl_pkg::ST_RUN);
   COV_OVR: cover property (cur_ff.ctrl[asl_pkg::CTL_OVR_EN] && led_red);
   COV_INV188: cover property (ind == asl_pkg::IND_V188I);
   COV_IRQ: cover property (irq ##1 !irq);
endmodule : asl_top

// ### tb/test_asi_input_status_led.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
$display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_asi_input_status_led;
   localparam int TC = 4;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, car = 0, lck = 0, cv = 0, inv = 0;
   logic ovf = 0, emp = 1;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, fd = 32'h0, rdat, rdata;
   logic [1:0] psz = 2'h0, rsp, bresp, rresp;
   logic awr, wrd, bv, arr, rv, pop, dma, crst, red, grn, irq;
   int err_count = 0, check_count = 0, pop_cnt = 0, r, g;
   asl_top #(.TICK_CYC(TC), .BOARD_TYPE(3'h5), .FW_REV(3'h3)) dut (.mclk(mclk), .rst_n(rst_n),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .rx_carrier(car), .rx_lock(lck), .rx_code_viol(cv),
      .rx_inverted(inv), .rx_pkt_size(psz), .fifo_overflow(ovf), .fifo_empty(emp),
      .fifo_data(fd), .fifo_pop(pop), .dma_en(dma), .chan_rst(crst), .led_red(red),
      .led_green(grn), .irq(irq));
   // clock and pop pulse counter
   always #20 mclk = ~mclk;
   always @(negedge mclk) if (pop === 1'b1) pop_cnt++;
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic tmo(inout int n);
      n++;
      if (n > 200)
      begin
         err_count++;
         print_verdict();
      end
   endtask : tmo
   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      bit da, dw, ta, tw, bd;
      n = 0; da = 0; dw = 0; bd = 0;
      @(posedge mclk);
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge mclk);
         tmo(n);
         ta = !da && awv && awr;
         tw = !dw && wv && wrd;
         @(posedge mclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         da |= ta;
         dw |= tw;
      end
      while (!bd)
      begin
         @(negedge mclk);
         tmo(n);
         if (bv) begin rsp = bresp; bd = 1; end
         @(posedge mclk);
         if (bd) bry <= 1'b0;
      end
   endtask : wr
   // bus read
   task automatic rd(input logic [7:0] a);
      int n;
      bit da, rd_done;
      n = 0; da = 0; rd_done = 0;
      @(posedge mclk);
      arv <= 1'b1; ara <= a; rry <= 1'b1;
      while (!da)
      begin
         @(negedge mclk);
         tmo(n);
         da = arr;
         @(posedge mclk);
         if (da) arv <= 1'b0;
      end
      while (!rd_done)
      begin
         @(negedge mclk);
         tmo(n);
         if (rv) begin rdat = rdata; rsp = rresp; rd_done = 1; end
         @(posedge mclk);
         if (rd_done) rry <= 1'b0;
      end
   endtask : rd
   task automatic cnt(input int c);
      r = 0; g = 0;
      repeat (c) begin @(negedge mclk); r += int'(red); g += int'(grn); end
   endtask : cnt
   // one-cycle pulse on code violation or, with sel_ovf, on overflow
   task automatic pulse(input bit sel_ovf);
      @(posedge mclk);
      if (sel_ovf) ovf <= 1'b1;
      else cv <= 1'b1;
      @(posedge mclk);
      ovf <= 1'b0;
      cv <= 1'b0;
   endtask : pulse
   // power-up pattern, reset values, id and unmapped access
   task automatic t_power;
      cnt(200);
      `CHK(r, 20)
      `CHK(g, 12)
      `CHK(irq, 1'b0)
      rd(asl_pkg::REG_STATUS);
      `CHK(rdat[7], 1'b1)
      `CHK(rdat[18:8], asl_pkg::IND_NODATA)
      rd(asl_pkg::REG_CTRL);
      `CHK(rdat, 32'h0)
      rd(asl_pkg::REG_ID);
      `CHK(rdat, 32'h53)
      rd(8'h20);
      `CHK(rsp, asl_pkg::RESP_DECERR)
      `CHK(rdat, 32'h0)
      wr(8'h20, 32'hFF);
      `CHK(rsp, asl_pkg::RESP_DECERR)
   endtask : t_power
   // every packet size with and without inversion
   task automatic t_valid;
      logic [10:0] ei[8] = '{asl_pkg::IND_VUNK, asl_pkg::IND_VUNK, asl_pkg::IND_V188,
         asl_pkg::IND_V188I, asl_pkg::IND_V204, asl_pkg::IND_V204I, asl_pkg::IND_VUNK,
         asl_pkg::IND_VUNK};
      int eg[8] = '{32, 32, 64, 60, 56, 52, 32, 32};
      @(posedge mclk); car <= 1'b1; lck <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk); psz <= 2'(i / 2); inv <= i[0];
         repeat (70) @(posedge mclk);
         cnt(64);
         `CHK(g, eg[i])
         `CHK(r, 0)
         rd(asl_pkg::REG_STATUS);
         `CHK(rdat[18:8], ei[i])
      end
      @(posedge mclk); psz <= asl_pkg::SIZE_188; inv <= 1'b0;
   endtask : t_valid
   // errors, interrupt mask and clear, loss of lock
   task automatic t_err;
      wr(asl_pkg::REG_IRQ_MASK, 32'h2);
      `CHK(rsp, asl_pkg::RESP_OKAY)
      wr(asl_pkg::REG_IRQ_STAT, 32'hF);
      `CHK(irq, 1'b0)
      pulse(1'b0);
      rd(asl_pkg::REG_STATUS);
      `CHK(rdat[18:8], asl_pkg::IND_CODEV)
      `CHK(irq, 1'b1)
      wr(asl_pkg::REG_IRQ_STAT, 32'h2);
      `CHK(irq, 1'b0)
      repeat (150) @(posedge mclk);
      rd(asl_pkg::REG_STATUS);
      `CHK(rdat[18:8], asl_pkg::IND_V188)
      pulse(1'b1);
      rd(asl_pkg::REG_STATUS);
      `CHK(rdat[18:8], asl_pkg::IND_OVF)
      rd(asl_pkg::REG_OVF_CNT);
      `CHK(rdat, 32'h1)
      `CHK(irq, 1'b0)
      wr(asl_pkg::REG_IRQ_MASK, 32'h4);
      `CHK(irq, 1'b1)
      wr(asl_pkg::REG_IRQ_STAT, 32'h4);
      `CHK(irq, 1'b0)
      pulse(1'b1);
      @(negedge mclk);
      `CHK(irq, 1'b1)
      @(posedge mclk); lck <= 1'b0;
      repeat (150) @(posedge mclk);
      cnt(64);
      `CHK(r, 64)
      `CHK(g, 0)
      rd(asl_pkg::REG_IRQ_STAT);
      `CHK(rdat[0], 1'b1)
   endtask : t_err
   // override and channel reset priority, fifo reads
   task automatic t_ctrl;
      wr(asl_pkg::REG_CTRL, 32'h08);
      repeat (3) @(posedge mclk);
      `CHK({red, grn, crst}, 3'h7)
      wr(asl_pkg::REG_CTRL, 32'h0D);
      repeat (3) @(posedge mclk);
      `CHK({red, grn, crst}, 3'h3)
      wr(asl_pkg::REG_CTRL, 32'h13);
      repeat (3) @(posedge mclk);
      `CHK({red, grn, crst, dma}, 4'h9)
      wr(asl_pkg::REG_CTRL, 32'h0);
      @(posedge mclk); emp <= 1'b0; fd <= 32'hA5C3_0F12;
      rd(asl_pkg::REG_FIFO_DATA);
      `CHK(rdat, 32'hA5C3_0F12)
      @(posedge mclk); emp <= 1'b1;
      rd(asl_pkg::REG_FIFO_DATA);
      `CHK(rdat, 32'h0)
      `CHK(pop_cnt, 1)
   endtask : t_ctrl
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_power();
      t_valid();
      t_err();
      t_ctrl();
      print_verdict();
   end
endmodule : test_asi_input_status_led
